//--- svs_pkg.sv
// Purpose: shared constants and types of the service window supervisor
// Assumes: one clock, hclk at 25 MHz, one hclk cycle per instruction cycle
// Notes:   offsets are byte addresses on the register bus
package svs_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int          CLK_MHZ            = 25;
  localparam logic [16:0] LOWER_LIMIT        = 17'h00100; // 256 cycles
  localparam int          UPPER_BASE_DEFAULT = 8192;      // 8k cycles
  localparam logic [4:0]  FAULT_HOLD_CYC     = 5'h18;     // 24, in 16..32
  localparam int          CM_TIMEOUT_US      = 1000;      // oscillator gap
  localparam int          CM_TIMEOUT_CYC     = CM_TIMEOUT_US * CLK_MHZ;
  localparam int          PROG_SIZE_DEFAULT  = 4096;      // program words

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_SVC   = 8'h00;
  localparam logic [7:0] ADDR_OPT   = 8'h04;
  localparam logic [7:0] ADDR_MODE  = 8'h08;
  localparam logic [7:0] ADDR_CORE  = 8'h0c;
  localparam logic [7:0] ADDR_FETCH = 8'h10;
  localparam logic [7:0] ADDR_SP    = 8'h14;
  localparam logic [7:0] ADDR_RAM   = 8'h18;

  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam int         SVC_SEL_LO  = 6;
  localparam int         SVC_KEY_LO  = 1;
  localparam int         SVC_CM_BIT  = 0;
  localparam logic [4:0] KEY_VALUE   = 5'h0c;   // 01100
  localparam logic [1:0] SEL_RESET   = 2'h3;
  localparam logic       CM_RESET    = 1'b1;
  localparam int         OPT_RC_BIT  = 0;
  localparam int         OPT_DLY_BIT = 1;
  localparam int         OPT_DIS_BIT = 2;
  localparam logic [2:0] OPT_RESET   = 3'h0;
  localparam int         MODE_HALT_BIT = 0;
  localparam int         MODE_IDLE_BIT = 1;
  localparam int         CORE_PENDING_RESET_INSTRUCTION_BIT = 0;
  localparam int         CORE_TRAP_BIT = 1;
  localparam logic [7:0] SP_RESET      = 8'h6f;
  localparam logic [6:0] RAM_UNUSED_LO = 7'h70;

  // supervisor states
  typedef enum logic [3:0] {
    SVS_ARMED  = 4'b0001,
    SVS_RUN    = 4'b0010,
    SVS_FDRIVE = 4'b0100,
    SVS_FWAIT  = 4'b1000
  } svs_state_t;
endpackage : svs_pkg

//--- svs_mon_if.sv
// Purpose: link between supervisor top and clock monitor
// Assumes: both ends on hclk
// Notes:   enable is level, hold is level
`timescale 1ns/1ps
`default_nettype none
interface svs_mon_if;
  logic cm_enable;  // monitor allowed to act
  logic cm_hold;    // monitor wants the fault pin low
  modport sup (output cm_enable, input cm_hold);
  modport mon (input cm_enable, output cm_hold);
endinterface : svs_mon_if
`default_nettype wire

//--- svs_clock_monitor.sv
// Purpose: oscillator presence monitor
// Assumes: oscillator_input is asynchronous to hclk
// Notes:   any edge of the oscillator restarts the gap timer
`timescale 1ns/1ps
`default_nettype none
module svs_clock_monitor
  import svs_pkg::*;
#(
  parameter int TIMEOUT_CYC = svs_pkg::CM_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic  hclk,
  input  wire logic  hresetn,
  // link to supervisor
  svs_mon_if.mon     mon,
  // pin
  input  wire logic  oscillator_input
);
  import svs_pkg::*;

  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic [23:0] cnt;
    logic        err;
    logic [4:0]  rec;
    logic        hold;
  } svs_mon_state_t;

  svs_mon_state_t q;
  svs_mon_state_t n;
  logic           edge_seen;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n         = q;
    edge_seen = 1'b0;
    n.sync    = {q.sync[1:0], oscillator_input};
    // filter: second and third stage agree before a change counts
    if (q.sync[1] == q.sync[2] && q.sync[2] != q.lvl) begin
      n.lvl     = q.sync[2];
      edge_seen = 1'b1;
    end
    if (!mon.cm_enable) begin
      n.cnt  = 24'h000000;
      n.err  = 1'b0;
      n.rec  = 5'h00;
    end else begin
      // a gap of 1 ms sits between 10 us and 10 ms half periods
      if (edge_seen) begin
        n.cnt = 24'h000000;
      end else if (q.cnt != 24'(TIMEOUT_CYC - 1)) begin
        n.cnt = q.cnt + 24'h000001;
      end else begin
        n.err = 1'b1;
      end
      // clock back: keep low a further 24 cycles, then let go
      if (q.err && edge_seen) begin
        n.err = 1'b0;
        n.rec = FAULT_HOLD_CYC;
      end else if (q.rec != 5'h00) begin
        n.rec = q.rec - 5'h01;
      end
    end
    n.hold = n.err | (n.rec != 5'h00);
  end

  // register; reset inhibits the detector
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign mon.cm_hold = q.hold;
endmodule : svs_clock_monitor
`default_nettype wire

//--- svs_top.sv
// Purpose: service window supervisor with clock monitor, AHB-Lite slave
// Assumes: one hclk cycle is one instruction cycle
// Notes:   fault pin is open drain, driven low only
`timescale 1ns/1ps
`default_nettype none
module svs_top
  import svs_pkg::*;
#(
  parameter int UPPER_BASE_CYCLES = svs_pkg::UPPER_BASE_DEFAULT,
  parameter int CM_TIMEOUT_CYCLES = svs_pkg::CM_TIMEOUT_CYC,
  parameter int PROG_SIZE         = svs_pkg::PROG_SIZE_DEFAULT
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // pins
  input  wire logic        oscillator_input,
  input  wire logic        fault_pin_in,
  output logic             fault_pin_out,
  output logic             fault_pin_oe,
  // core status
  output logic             trap_pending_flag,
  output logic             interrupts_blocked
);
  import svs_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    svs_state_t  st;
    logic [2:0]  pin_sync;
    logic        pin_lvl;
    logic [1:0]  sel;
    logic        cm_en;
    logic        configured;
    logic [16:0] cnt;
    logic [4:0]  hold_cnt;
    logic [2:0]  opt;
    logic        halt;
    logic        idle;
    logic        trap;
    logic [7:0]  sp;
    logic [6:0]  ram_addr;
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
    logic        ready;
    logic [31:0] rdata;
    logic        oe;
    logic        pin_out;
  } svs_top_state_t;

  svs_top_state_t q;
  svs_top_state_t n;

  svs_mon_if mon_link ();

  logic        enabled;
  logic        ahb_go;
  logic        wr_fire;
  logic        svc_wr;
  logic [7:0]  wdat;
  logic [16:0] upper_m1;
  logic        timing_run;
  logic        restart_evt;
  logic        key_ok;
  logic        all_ok;
  logic        go_fault;
  logic        trap_set;
  logic        trap_clr;
  logic        new_halt;
  logic        new_idle;

  // ---------------------------------------------------------------
  // clock monitor
  // ---------------------------------------------------------------
  svs_clock_monitor #(
    .TIMEOUT_CYC      (CM_TIMEOUT_CYCLES)
  ) u_mon (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .mon              (mon_link.mon),
    .oscillator_input (oscillator_input)
  );

  // monitor acts only with the supervisor enabled and selected
  assign mon_link.cm_enable = q.cm_en & ~q.opt[OPT_DIS_BIT];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    n           = q;
    enabled     = ~q.opt[OPT_DIS_BIT];
    wdat        = hwdata[7:0];
    ahb_go      = hsel & hready & htrans[1];
    wr_fire     = q.wr_pend & hready;
    go_fault    = 1'b0;
    trap_set    = 1'b0;
    trap_clr    = 1'b0;
    new_halt    = q.halt;
    new_idle    = q.idle;
    // 8k shifted by window select; 64k still fits 17 bits
    upper_m1    = (17'(UPPER_BASE_CYCLES) << q.sel) - 17'h00001;
    key_ok      = wdat[5:1] == KEY_VALUE;
    all_ok      = key_ok && wdat[7:6] == q.sel
                  && wdat[SVC_CM_BIT] == q.cm_en;
    // service register writes during an active fault pin are dropped
    svc_wr      = wr_fire && q.addr == ADDR_SVC && enabled
                  && !q.oe;

    // fault pin sync: three stages, change once 2nd and 3rd agree
    n.pin_sync = {q.pin_sync[1:0], fault_pin_in};
    if (q.pin_sync[1] == q.pin_sync[2]) begin
      n.pin_lvl = q.pin_sync[2];
    end

    // bus: writes take no wait, reads take one wait state so that
    // a read right after a write sees the written value
    n.wr_pend = ahb_go & hwrite;
    n.rd_pend = ahb_go & ~hwrite;
    n.ready   = ~(ahb_go & ~hwrite);
    if (ahb_go) begin
      n.addr = haddr[7:0];
    end
    if (q.rd_pend) begin
      n.ready = 1'b1;
      case (q.addr)
        ADDR_SVC:  n.rdata = {24'h000000, q.sel, 5'h00, q.cm_en};
        ADDR_OPT:  n.rdata = {29'h00000000, q.opt};
        ADDR_MODE: n.rdata = {24'h000000, q.trap, q.configured,
                              mon_link.cm_hold, q.oe, 2'h0,
                              q.idle, q.halt};
        ADDR_CORE: n.rdata = {30'h00000000, 1'b0, q.trap};
        ADDR_SP:   n.rdata = {24'h000000, q.sp};
        // unused RAM from 70 upward reads as ff, the upper bytes zero
        ADDR_RAM:  n.rdata = (q.ram_addr >= RAM_UNUSED_LO)
                             ? 32'h000000ff : 32'h00000000;
        default:   n.rdata = 32'h00000000;
      endcase
    end

    // register writes other than the service register
    if (wr_fire) begin
      case (q.addr)
        ADDR_OPT: n.opt = wdat[2:0];
        ADDR_MODE: begin
          new_halt = wdat[MODE_HALT_BIT];
          new_idle = wdat[MODE_IDLE_BIT];
        end
        ADDR_CORE: begin
          trap_clr = wdat[CORE_PENDING_RESET_INSTRUCTION_BIT];
          trap_set = wdat[CORE_TRAP_BIT];
        end
        // a fetch beyond program memory yields opcode 00, a trap
        ADDR_FETCH: trap_set = hwdata[15:0] >= 16'(PROG_SIZE);
        ADDR_SP:  n.sp = wdat;
        ADDR_RAM: n.ram_addr = wdat[6:0];
        default: ;
      endcase
    end
    n.halt = new_halt;
    n.idle = new_idle;

    // idle exit services; halt exit reloads unless RC without delay
    restart_evt = (q.idle && !new_idle)
                  || (q.halt && !new_halt
                      && !(q.opt[OPT_RC_BIT]
                           && !q.opt[OPT_DLY_BIT]));
    timing_run  = !q.halt && !q.idle;

    // supervisor sequence
    case (q.st)
      SVS_ARMED: begin
        if (svc_wr) begin
          // first write: no lower limit, fixes window and monitor
          if (key_ok) begin
            n.sel        = wdat[7:SVC_SEL_LO];
            n.cm_en      = wdat[SVC_CM_BIT];
            n.configured = 1'b1;
            n.cnt        = 17'h00000;
            n.st         = SVS_RUN;
          end else begin
            go_fault = 1'b1;
          end
        end else if (restart_evt) begin
          n.cnt = 17'h00000;
        end else if (timing_run) begin
          if (q.cnt == upper_m1) begin
            go_fault = 1'b1;
          end else begin
            n.cnt = q.cnt + 17'h00001;
          end
        end
      end
      SVS_RUN: begin
        if (svc_wr) begin
          if (all_ok && q.cnt >= LOWER_LIMIT) begin
            n.cnt = 17'h00000;
          end else begin
            go_fault = 1'b1;
          end
        end else if (restart_evt) begin
          n.cnt = 17'h00000;
        end else if (timing_run) begin
          if (q.cnt == upper_m1) begin
            go_fault = 1'b1;
          end else begin
            n.cnt = q.cnt + 17'h00001;
          end
        end
      end
      SVS_FDRIVE: begin
        // count only once the pin has really fallen
        if (!q.pin_lvl) begin
          if (q.hold_cnt == FAULT_HOLD_CYC - 5'h01) begin
            n.st = SVS_FWAIT;
          end else begin
            n.hold_cnt = q.hold_cnt + 5'h01;
          end
        end
      end
      SVS_FWAIT: begin
        // window restarts when the pin is seen high again
        if (q.pin_lvl) begin
          n.cnt = 17'h00000;
          n.st  = q.configured ? SVS_RUN : SVS_ARMED;
        end
      end
      default: begin
        n.st = SVS_ARMED;
      end
    endcase

    if (go_fault) begin
      n.st       = SVS_FDRIVE;
      n.hold_cnt = 5'h00;
    end
    // disabled: pin is ordinary, detector parked
    if (!enabled) begin
      n.st  = q.configured ? SVS_RUN : SVS_ARMED;
      n.cnt = 17'h00000;
    end

    // either detector alone pulls the pin
    n.oe      = enabled && (n.st == SVS_FDRIVE
                            || mon_link.cm_hold);
    n.pin_out = 1'b0;

    // trap flag: a set in the same cycle as a clear wins
    if (trap_set) begin
      n.trap = 1'b1;
    end else if (trap_clr) begin
      n.trap = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q            <= '0;
      q.st         <= SVS_ARMED;
      q.sel        <= SEL_RESET;
      q.cm_en      <= CM_RESET;
      q.opt        <= OPT_RESET;
      q.sp         <= SP_RESET;
      q.pin_sync   <= 3'h7;
      q.pin_lvl    <= 1'b1;
      q.ready      <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops; hresp tied low
  assign hreadyout          = q.ready;
  assign hresp              = 1'b0;
  assign hrdata             = q.rdata;
  assign fault_pin_out      = q.pin_out;
  assign fault_pin_oe       = q.oe;
  assign trap_pending_flag  = q.trap;
  assign interrupts_blocked = q.trap;
endmodule : svs_top
`default_nettype wire

//--- svs_pin_env.sv
// Purpose: board side of the fault pin and the oscillator source
// Assumes: the fault line has only a weak pull-up besides the device
// Notes:   the oscillator stands flat while stopped, as a dead crystal
`timescale 1ns/1ps
`default_nettype none
module svs_pin_env (
  // fault line
  input  wire logic fault_pin_oe,
  input  wire logic fault_pin_out,
  output logic      fault_wire,
  // oscillator
  input  wire logic osc_run,
  output var logic  oscillator_input
);
  // ---------------------------------------------------------------
  // pull-up and oscillator
  // ---------------------------------------------------------------
  // a released line floats back up to the pull-up level
  assign fault_wire = fault_pin_oe ? fault_pin_out : 1'b1;
  // half period: 136 ns never meets an hclk rising edge, and each level
  // spans three or more samples so the two-stage agree filter sees it
  initial oscillator_input = 1'b0;
  always #136 begin
    if (osc_run) begin
      oscillator_input = ~oscillator_input;
    end
  end
endmodule : svs_pin_env
`default_nettype wire

//--- svs_top_sva.sv
// Purpose: port checks of the service window supervisor
// Assumes: hready is looped back from hreadyout
// Notes:   bound to svs_top below
`timescale 1ns/1ps
`default_nettype none
module svs_top_sva
  import svs_pkg::*;
#(
  parameter int PROG_SIZE = 4096
) (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins and status
  input wire logic        fault_pin_out,
  input wire logic        fault_pin_oe,
  input wire logic        trap_pending_flag,
  input wire logic        interrupts_blocked
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic       taken;
  logic       fetch_q;
  logic       core_q;
  logic [7:0] oe_cnt;
  assign taken = hsel & hready & htrans[1];
  // data-phase markers; oe_cnt saturates so long monitor holds stay sane
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_q <= 1'b0;
      core_q  <= 1'b0;
      oe_cnt  <= 8'h00;
    end else begin
      fetch_q <= taken & hwrite & (haddr[7:0] == ADDR_FETCH);
      core_q  <= taken & hwrite & (haddr[7:0] == ADDR_CORE);
      oe_cnt  <= fault_pin_oe ? oe_cnt + {7'h0, oe_cnt != 8'hff} : 8'h00;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_pin_low_only: assert property (fault_pin_oe |-> !fault_pin_out)
    else $error("fault pin driven high");
  chk_quiet_reset: assert property ($rose(hresetn) |-> (!fault_pin_oe) [*8])
    else $error("fault pin pulled right after reset");
  chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("error response");
  chk_trap_mirror: assert property (interrupts_blocked == trap_pending_flag)
    else $error("blocking differs from trap flag");
  chk_trap_set: assert property (fetch_q && {16'h0, hwdata[15:0]} >= PROG_SIZE |=> trap_pending_flag)
    else $error("fetch past end did not trap");
  chk_trap_hold: assert property (trap_pending_flag && !(core_q && hwdata[0]) |=> trap_pending_flag)
    else $error("trap flag cleared without clear");
  chk_fault_hold: assert property ($fell(fault_pin_oe) |-> oe_cnt >= 8'd16)
    else $error("fault pulse too short");
  cov_fault_end: cover property ($fell(fault_pin_oe));
  cov_trap_set: cover property ($rose(trap_pending_flag));
  cov_read: cover property (taken && !hwrite);
endmodule : svs_top_sva
bind svs_top svs_top_sva #(.PROG_SIZE(PROG_SIZE)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .fault_pin_out(fault_pin_out),
  .fault_pin_oe(fault_pin_oe), .trap_pending_flag(trap_pending_flag),
  .interrupts_blocked(interrupts_blocked));
`default_nettype wire

//--- svs_top_test.sv
// Purpose: self-checking bench of the service window supervisor
// Assumes: windows shortened to a 512 base, monitor gap to 64 cycles
// Notes:   one reset per window select; detail tests in the first pass
`timescale 1ns/1ps
`default_nettype none
module svs_top_test;
  import svs_pkg::*;
  localparam int UB  = 512;
  localparam int CMT = 64;
  logic        hclk, hresetn, hsel, hwrite, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0]  htrans, st;
  logic        fault_pin_out, fault_pin_oe, fault_wire;
  logic        trap, blocked, osc, osc_run;
  int          fail_count, samples_checked, n;
  always #20 hclk = ~hclk;
  svs_top #(.UPPER_BASE_CYCLES(UB), .CM_TIMEOUT_CYCLES(CMT)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .oscillator_input(osc), .fault_pin_in(fault_wire),
    .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe),
    .trap_pending_flag(trap), .interrupts_blocked(blocked));
  svs_pin_env env (
    .fault_pin_oe(fault_pin_oe), .fault_pin_out(fault_pin_out),
    .fault_wire(fault_wire), .osc_run(osc_run), .oscillator_input(osc));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [31:0] svc(input logic [1:0] s, input logic c);
    return {24'h0, s, KEY_VALUE, c};
  endfunction : svc
  task automatic chk(input logic [31:0] seen, exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask : chk
  // ready sampled half a cycle early, where it stands still
  task automatic wait_rdy();
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      rd = hrdata;
      st = {blocked, trap};
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask : xfer
  task automatic chk_oe(input int k, input logic e, input string w);
    repeat (k) @(posedge hclk);
    @(negedge hclk);
    chk({31'h0, fault_pin_oe}, {31'h0, e}, w);
    @(posedge hclk);
  endtask : chk_oe
  // cycles until the pin drive reaches lvl, capped so a hang shows
  task automatic span(input logic lvl, output int k);
    k = 0;
    @(negedge hclk);
    while (fault_pin_oe !== lvl && k < 9000) begin
      k++;
      @(negedge hclk);
    end
    @(posedge hclk);
  endtask : span
  task automatic await_release();
    int k;
    span(1'b0, k);
    chk({31'h0, k inside {[17:37]}}, 32'h1, "fault hold");
  endtask : await_release
  task automatic conclude();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #(40 * 40000);
    fail_count++;
    conclude();
  end
  initial begin
    logic [31:0] m;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    osc_run = 1'b1;
    seed = 32'h8ffb3978;
    fail_count = 0;
    samples_checked = 0;
    for (int s = 0; s < 4; s++) begin
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      if (s == 0) begin
        xfer(0, ADDR_SVC, 0);
        chk(rd, {24'h0, SEL_RESET, 5'h0, CM_RESET}, "svc reset");
        xfer(0, ADDR_SP, 0);
        chk(rd, {24'h0, SP_RESET}, "stack reset");
        for (int i = 0; i < 4; i++) begin
          seed = xs(seed);
          m = (i == 0) ? 32'h70 : (i == 1) ? 32'h6f : {25'h0, seed[6:0]};
          xfer(1, ADDR_RAM, m);
          xfer(0, ADDR_RAM, 0);
          chk(rd, (m[6:0] >= RAM_UNUSED_LO) ? 32'hff : 32'h0, "ram");
        end
      end
      xfer(1, ADDR_SVC, svc(s[1:0], s != 2));
      chk_oe(3, 1'b0, "first service");
      if (s == 0) begin
        xfer(0, ADDR_SVC, 0);
        chk(rd, 32'h01, "svc readback");
        xfer(1, ADDR_SVC, svc(0, 1));
        chk_oe(2, 1'b1, "early service");
        xfer(1, ADDR_SVC, 32'h0);
        await_release();
        chk_oe(300, 1'b0, "write during fault");
        xfer(1, ADDR_SVC, svc(0, 1));
        chk_oe(3, 1'b0, "valid service");
        for (int f = 0; f < 3; f++) begin
          seed = xs(seed);
          m = (f == 0) ? 32'hc0 : (f == 1) ? 32'h3e : 32'h01;
          repeat (300) @(posedge hclk);
          xfer(1, ADDR_SVC, svc(0, 1) ^ ((seed & m) | (m & (~m + 32'h1))));
          chk_oe(2, 1'b1, "field mismatch");
          await_release();
        end
      end
      span(1'b1, n);
      chk({31'h0, n inside {[(UB << s) - 10:(UB << s) + 6]}}, 32'h1,
          "window expiry");
      await_release();
      if (s == 0) begin
        seed = xs(seed);
        xfer(1, ADDR_FETCH, {20'h0, seed[11:0]});
        xfer(0, ADDR_CORE, 0);
        chk({29'h0, st, rd[0]}, 32'h0, "fetch inside");
        xfer(1, ADDR_FETCH, {16'h0, seed[15:0] | 16'h1000});
        xfer(1, ADDR_FETCH, {20'h0, seed[11:0]});
        xfer(0, ADDR_CORE, 0);
        chk({29'h0, st, rd[0]}, 32'h7, "trap stays set");
        xfer(1, ADDR_CORE, 32'h1);
        xfer(0, ADDR_CORE, 0);
        chk({29'h0, st, rd[0]}, 32'h0, "trap cleared");
        for (int k = 0; k < 4; k++) begin
          // crystal, idle, RC without delay, RC with delay
          m = (k == 2) ? 32'h1 : (k == 3) ? 32'h3 : 32'h0;
          xfer(1, ADDR_OPT, m);
          xfer(0, ADDR_OPT, 0);
          chk(rd, m, "option readback");
          repeat (300) @(posedge hclk);
          xfer(1, ADDR_MODE, (k == 1) ? 32'h2 : 32'h1);
          repeat (20) @(posedge hclk);
          xfer(1, ADDR_MODE, 0);
          xfer(1, ADDR_SVC, svc(0, 1));
          chk_oe(2, k != 2, "service after wake");
          if (k != 2) await_release();
        end
      end
      if (s == 1 || s == 2) begin
        osc_run <= 1'b0;
        chk_oe(CMT + 12, s == 1, "clock stopped");
        chk_oe(100, s == 1, "clock still stopped");
        osc_run <= 1'b1;
        if (s == 1) await_release();
      end
      if (s == 3) begin
        xfer(1, ADDR_OPT, 32'h4);
        xfer(1, ADDR_SVC, 32'h0);
        chk_oe(3, 1'b0, "disabled");
      end
    end
    conclude();
  end
endmodule : svs_top_test
`default_nettype wire
